// ### core/tcpwm_if.sv
// Configuration and status carrier between register file and one timer
`timescale 1ns/1ns
interface tcpwm_if;
  logic                               enable;
  logic [1:0]                         mode;
  logic [2:0]                         cmp_mode;
  logic [1:0]                         clk_sel;
  logic                               compl_en;
  logic [tcpwm_pkg::NUM_SRC-1:0]      tick_src;
  logic [tcpwm_pkg::CNT_W-1:0]        period;
  logic [tcpwm_pkg::CNT_W-1:0]        compare;
  logic [tcpwm_pkg::DB_W-1:0]         deadband;
  logic                               rst_in;
  logic                               cap_in;
  logic                               en_in;
  logic                               kill_in;
  logic [tcpwm_pkg::CNT_W-1:0]        count;
  logic [tcpwm_pkg::CNT_W-1:0]        capture;
  logic [tcpwm_pkg::EV_W-1:0]         events;

  modport regs (output enable, mode, cmp_mode, clk_sel, compl_en, tick_src, period, compare, deadband,
                output rst_in, cap_in, en_in, kill_in, input count, capture, events);
  modport unit (input enable, mode, cmp_mode, clk_sel, compl_en, tick_src, period, compare, deadband,
                input rst_in, cap_in, en_in, kill_in, output count, capture, events);
endinterface

// ### core/tcpwm_pkg.sv
// Shared constants and types of the down-count timer, counter and PWM
package tcpwm_pkg;

  localparam int NUM_INST   = 4;
  localparam int CNT_W      = 16;
  localparam int DB_W       = 8;
  localparam int ADDR_W     = 12;
  localparam int NUM_SRC    = 4;
  localparam int EV_W       = 3;
  localparam int EV_STRIDE  = 4;
  localparam int STAT_W     = NUM_INST * EV_STRIDE;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0]        OFF_CTRL       = 5'h00;
  localparam logic [4:0]        OFF_PERIOD     = 5'h04;
  localparam logic [4:0]        OFF_COMPARE    = 5'h08;
  localparam logic [4:0]        OFF_COUNT      = 5'h0C;
  localparam logic [4:0]        OFF_CAPTURE    = 5'h10;
  localparam logic [4:0]        OFF_DEADBAND   = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 12'h080;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK   = 12'h084;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_CMP_LSB   = 3;
  localparam int CTRL_CLK_LSB   = 6;
  localparam int CTRL_IRQ_LSB   = 8;
  localparam int CTRL_COMPL_BIT = 11;
  localparam int CTRL_W         = 12;

  localparam logic [CTRL_W-1:0] CTRL_RST     = 12'h000;
  localparam logic [CNT_W-1:0]  PERIOD_RST   = 16'hFFFF;
  localparam logic [CNT_W-1:0]  COMPARE_RST  = 16'h0000;
  localparam logic [DB_W-1:0]   DEADBAND_RST = 8'h00;

  localparam int EV_TC  = 0;
  localparam int EV_CMP = 1;
  localparam int EV_CAP = 2;

  localparam int PRESC_A_DIV = 4;
  localparam int PRESC_B_DIV = 16;

  typedef enum logic [1:0] {
    mode_free    = 2'b00,
    mode_oneshot = 2'b01,
    mode_enable  = 2'b10
  } run_mode_t;

  typedef enum logic [2:0] {
    cmp_less             = 3'b000,
    cmp_less_or_equal    = 3'b001,
    cmp_equal            = 3'b010,
    cmp_greater_or_equal = 3'b011,
    cmp_greater          = 3'b100
  } cmp_mode_t;

endpackage

// ### core/tcpwm_top.sv
// Four down-count timer, counter and PWM channels behind an APB register file
//
// Overview of operation
// - Sixteen-bit counter counts down only
// - Four identical independent timer instances
// - Counting clock picked from several sources
// - Comparator: less, less-equal, equal, greater-equal, greater
// - Period reloads on start, reset, terminal count; one-shot mode holds the count at zero at terminal count
// - Interrupt on terminal count, compare, capture
// - Free-running mode keeps counting every period
// - One-shot mode stops at period end
// - Enable mode counts only while enable high
// - Capture latches full sixteen-bit count
// - Compare, terminal count or complement, interrupt
// - Complementary outputs separated by programmable deadband
// - Kill forces comparator outputs inactive
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ns
module tcpwm_top #(
  parameter int PRESC_A = tcpwm_pkg::PRESC_A_DIV,
  parameter int PRESC_B = tcpwm_pkg::PRESC_B_DIV
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [tcpwm_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [tcpwm_pkg::NUM_INST-1:0]   ext_clk_in,
  input  wire logic [tcpwm_pkg::NUM_INST-1:0]   reset_in,
  input  wire logic [tcpwm_pkg::NUM_INST-1:0]   capture_in,
  input  wire logic [tcpwm_pkg::NUM_INST-1:0]   enable_in,
  input  wire logic [tcpwm_pkg::NUM_INST-1:0]   kill_in,
  output logic      [tcpwm_pkg::NUM_INST-1:0]   cmp_out,
  output logic      [tcpwm_pkg::NUM_INST-1:0]   tc_out,
  output logic      [tcpwm_pkg::NUM_INST-1:0]   irq_line,
  output logic                                  irq
);

  localparam int N   = tcpwm_pkg::NUM_INST;
  localparam int PW  = 5 * N;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [tcpwm_pkg::CTRL_W-1:0]  ctrl_q     [N];
  logic [tcpwm_pkg::CNT_W-1:0]   period_q   [N];
  logic [tcpwm_pkg::CNT_W-1:0]   compare_q  [N];
  logic [tcpwm_pkg::DB_W-1:0]    deadband_q [N];
  logic [tcpwm_pkg::CNT_W-1:0]   count_w    [N];
  logic [tcpwm_pkg::CNT_W-1:0]   capture_w  [N];
  logic [tcpwm_pkg::STAT_W-1:0]  status_q, mask_q, ev_set, status_clr;
  logic [PW-1:0]                 pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic [N-1:0]                  ext_q, ext_tick;
  logic [7:0]                    presc_a_q, presc_b_q;
  logic                          tick_a, tick_b;
  logic                          wr_en, setup;
  logic [31:0]                   rdata_d, rdata_q;
  logic                          err_d, err_q;

  tcpwm_if u_if [N] ();

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  function automatic logic is_inst(input logic [tcpwm_pkg::ADDR_W-1:0] a);
    is_inst = a < tcpwm_pkg::OFF_INT_STATUS;
  endfunction

  function automatic int inst_of(input logic [tcpwm_pkg::ADDR_W-1:0] a);
    inst_of = int'(a[6:5]);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_f_q  <= '0;
    end else begin
      pin_s1_q <= {ext_clk_in, reset_in, capture_in, enable_in, kill_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= (~(pin_s2_q ^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_f_q);
    end
  end

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  assign tick_a   = presc_a_q == 8'(PRESC_A - 1);
  assign tick_b   = presc_b_q == 8'(PRESC_B - 1);
  assign ext_tick = pin_f_q[4*N +: N] & ~ext_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_a_q <= 8'h00;
      presc_b_q <= 8'h00;
      ext_q     <= '0;
    end else begin
      presc_a_q <= tick_a ? 8'h00 : presc_a_q + 8'h01;
      presc_b_q <= tick_b ? 8'h00 : presc_b_q + 8'h01;
      ext_q     <= pin_f_q[4*N +: N];
    end
  end

  // ----------------------------------------------------------------
  // Timer instances
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_inst
    assign u_if[g].enable   = ctrl_q[g][tcpwm_pkg::CTRL_EN_BIT];
    assign u_if[g].mode     = ctrl_q[g][tcpwm_pkg::CTRL_MODE_LSB +: 2];
    assign u_if[g].cmp_mode = ctrl_q[g][tcpwm_pkg::CTRL_CMP_LSB +: 3];
    assign u_if[g].clk_sel  = ctrl_q[g][tcpwm_pkg::CTRL_CLK_LSB +: 2];
    assign u_if[g].compl_en = ctrl_q[g][tcpwm_pkg::CTRL_COMPL_BIT];
    assign u_if[g].tick_src = {ext_tick[g], tick_b, tick_a, 1'b1};
    assign u_if[g].period   = period_q[g];
    assign u_if[g].compare  = compare_q[g];
    assign u_if[g].deadband = deadband_q[g];
    assign u_if[g].rst_in   = pin_f_q[3*N + g];
    assign u_if[g].cap_in   = pin_f_q[2*N + g];
    assign u_if[g].en_in    = pin_f_q[N + g];
    assign u_if[g].kill_in  = pin_f_q[g];
    assign count_w[g]       = u_if[g].count;
    assign capture_w[g]     = u_if[g].capture;
    assign ev_set[g*tcpwm_pkg::EV_STRIDE +: tcpwm_pkg::EV_STRIDE] =
      {1'b0, u_if[g].events & ctrl_q[g][tcpwm_pkg::CTRL_IRQ_LSB +: tcpwm_pkg::EV_W]};

    tcpwm_unit u_unit (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (u_if[g]),
      .cmp_out (cmp_out[g]),
      .tc_out  (tc_out[g])
    );
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & err_q;
  assign prdata  = rdata_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      err_d = 1'b1;
    end else if (is_inst(paddr)) begin
      unique case (paddr[4:0])
        tcpwm_pkg::OFF_CTRL:     rdata_d = 32'(ctrl_q[inst_of(paddr)]);
        tcpwm_pkg::OFF_PERIOD:   rdata_d = 32'(period_q[inst_of(paddr)]);
        tcpwm_pkg::OFF_COMPARE:  rdata_d = 32'(compare_q[inst_of(paddr)]);
        tcpwm_pkg::OFF_COUNT:    rdata_d = 32'(count_w[inst_of(paddr)]);
        tcpwm_pkg::OFF_CAPTURE:  rdata_d = 32'(capture_w[inst_of(paddr)]);
        tcpwm_pkg::OFF_DEADBAND: rdata_d = 32'(deadband_q[inst_of(paddr)]);
        default:                 err_d   = 1'b1;
      endcase
    end else if (paddr == tcpwm_pkg::OFF_INT_STATUS) begin
      rdata_d = 32'(status_q);
    end else if (paddr == tcpwm_pkg::OFF_INT_MASK) begin
      rdata_d = 32'(mask_q);
    end else begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        ctrl_q[i]     <= tcpwm_pkg::CTRL_RST;
        period_q[i]   <= tcpwm_pkg::PERIOD_RST;
        compare_q[i]  <= tcpwm_pkg::COMPARE_RST;
        deadband_q[i] <= tcpwm_pkg::DEADBAND_RST;
      end
    end else if (wr_en && !err_q && is_inst(paddr)) begin
      unique case (paddr[4:0])
        tcpwm_pkg::OFF_CTRL:     ctrl_q[inst_of(paddr)]     <= pwdata[tcpwm_pkg::CTRL_W-1:0];
        tcpwm_pkg::OFF_PERIOD:   period_q[inst_of(paddr)]   <= pwdata[tcpwm_pkg::CNT_W-1:0];
        tcpwm_pkg::OFF_COMPARE:  compare_q[inst_of(paddr)]  <= pwdata[tcpwm_pkg::CNT_W-1:0];
        tcpwm_pkg::OFF_DEADBAND: deadband_q[inst_of(paddr)] <= pwdata[tcpwm_pkg::DB_W-1:0];
        default:                 ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign status_clr = (wr_en && paddr == tcpwm_pkg::OFF_INT_STATUS) ? pwdata[tcpwm_pkg::STAT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      mask_q   <= '0;
    end else begin
      status_q <= (status_q & ~status_clr) | ev_set;
      if (wr_en && paddr == tcpwm_pkg::OFF_INT_MASK) begin
        mask_q <= pwdata[tcpwm_pkg::STAT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq      <= 1'b0;
      irq_line <= '0;
    end else begin
      irq <= |(status_q & mask_q);
      for (int i = 0; i < N; i++) begin
        irq_line[i] <= |(status_q[i*tcpwm_pkg::EV_STRIDE +: tcpwm_pkg::EV_STRIDE] &
                         mask_q[i*tcpwm_pkg::EV_STRIDE +: tcpwm_pkg::EV_STRIDE]);
      end
    end
  end

endmodule

// ### core/tcpwm_unit.sv
// One down-counting timer, counter and PWM channel
`timescale 1ns/1ns
module tcpwm_unit (
  input  wire logic pclk,
  input  wire logic presetn,
  tcpwm_if.unit     bus,
  output logic      cmp_out,
  output logic      tc_out
);

  logic                        en_q, rst_q, cap_q, run_q, cmp_q;
  logic                        tick, start, rst_edge, cap_edge, active, at_zero, tc_level, cmp_raw, db_done;
  logic [tcpwm_pkg::CNT_W-1:0] count_q, capture_q;
  logic [tcpwm_pkg::DB_W-1:0]  db_cnt_q;

  function automatic logic cmp_true(input logic [2:0] m, input logic [15:0] c, input logic [15:0] v);
    unique case (m)
      tcpwm_pkg::cmp_less:             cmp_true = c < v;
      tcpwm_pkg::cmp_less_or_equal:    cmp_true = c <= v;
      tcpwm_pkg::cmp_equal:            cmp_true = c == v;
      tcpwm_pkg::cmp_greater_or_equal: cmp_true = c >= v;
      tcpwm_pkg::cmp_greater:          cmp_true = c > v;
      default:                         cmp_true = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  assign tick     = bus.tick_src[bus.clk_sel];
  assign start    = bus.enable & ~en_q;
  assign rst_edge = bus.rst_in & ~rst_q;
  assign cap_edge = bus.cap_in & ~cap_q;
  assign at_zero  = count_q == 16'h0000;
  assign active   = run_q & tick & ((bus.mode != tcpwm_pkg::mode_enable) | bus.en_in);
  assign tc_level = run_q & at_zero;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q  <= 1'b0;
      rst_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      en_q  <= bus.enable;
      rst_q <= bus.rst_in;
      cap_q <= bus.cap_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (!bus.enable) begin
      run_q <= 1'b0;
    end else if (start | rst_edge) begin
      run_q <= 1'b1;
    end else if (active & at_zero & (bus.mode == tcpwm_pkg::mode_oneshot)) begin
      run_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= tcpwm_pkg::PERIOD_RST;
    end else if (start | rst_edge) begin
      count_q <= bus.period;
    end else if (active) begin
      if (!at_zero) begin
        count_q <= count_q - 16'h0001;
      end else if (bus.mode != tcpwm_pkg::mode_oneshot) begin
        count_q <= bus.period;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= 16'h0000;
    end else if (cap_edge) begin
      capture_q <= count_q;
    end
  end

  // ----------------------------------------------------------------
  // Compare, deadband and kill
  // ----------------------------------------------------------------
  assign cmp_raw = bus.enable & cmp_true(bus.cmp_mode, count_q, bus.compare);
  assign db_done = db_cnt_q == bus.deadband;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q    <= 1'b0;
      db_cnt_q <= 8'h00;
    end else begin
      cmp_q <= cmp_raw;
      if (cmp_raw != cmp_q) begin
        db_cnt_q <= 8'h00;
      end else if (!db_done) begin
        db_cnt_q <= db_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_out <= 1'b0;
      tc_out  <= 1'b0;
    end else begin
      cmp_out <= ~bus.kill_in & cmp_q & db_done;
      tc_out  <= bus.compl_en ? (~bus.kill_in & ~cmp_q & db_done) : tc_level;
    end
  end

  assign bus.count   = count_q;
  assign bus.capture = capture_q;
  assign bus.events  = {cap_edge, cmp_raw & ~cmp_q, active & at_zero};

endmodule

// ### dv/down_count_timer_pwm_tb.sv
// Self-checking testbench of the timer block
`timescale 1ns/1ns
module down_count_timer_pwm_tb;
  localparam logic [11:0] CT = 12'(tcpwm_pkg::OFF_CTRL);
  localparam logic [11:0] PE = 12'(tcpwm_pkg::OFF_PERIOD);
  localparam logic [11:0] CM = 12'(tcpwm_pkg::OFF_COMPARE);
  localparam logic [11:0] CN = 12'(tcpwm_pkg::OFF_COUNT);
  localparam logic [11:0] CP = 12'(tcpwm_pkg::OFF_CAPTURE);
  localparam logic [11:0] DB = 12'(tcpwm_pkg::OFF_DEADBAND);
  localparam logic [11:0] ST = tcpwm_pkg::OFF_INT_STATUS;
  localparam logic [11:0] MK = tcpwm_pkg::OFF_INT_MASK;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr, e, ov;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, a;
  logic [3:0]  ext_clk_in, reset_in, capture_in, enable_in, kill_in, cmp_out, tc_out, irq_line;
  int          n_errors, num_checks, cyc, n;

  tcpwm_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_clk_in, .reset_in, .capture_in, .enable_in, .kill_in, .cmp_out, .tc_out, .irq_line, .irq);
  tcpwm_pins u_pins (.pclk, .ext_clk_in, .reset_in, .capture_in, .enable_in, .kill_in);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic err(input string m);
    n_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  function automatic bit bad(input bit c);
    num_checks++;
    return c;
  endfunction
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd(input logic [11:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] c, input logic [1:0] k,
                                     input logic [2:0] q, input logic x);
    return 32'({x, q, k, c, m, 1'b1});
  endfunction
  task automatic wait_tc;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (tc_out[0] !== 1'b1 && n < 600);
    if (bad(n >= 600)) err("no terminal count");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      rd(12'(i * 32) + PE);
      if (bad(rdata !== 32'h0000FFFF)) err("period reset");
      wr(12'(i * 32) + PE, 32'(i + 7));
    end
    for (int i = 0; i < 4; i++) begin
      rd(12'(i * 32) + PE);
      if (bad(rdata !== 32'(i + 7))) err("period per instance");
    end
    wr(CN, 32'h5);
    rd(CN);
    if (bad(rdata !== 32'h0000FFFF)) err("count write");
    rd(12'h018);
    if (bad(rerr !== 1'b1 || rdata !== 32'h0)) err("unused offset");
    rd(12'h002);
    if (bad(rerr !== 1'b1)) err("unaligned");
    rd(CT);
    if (bad(rdata !== 32'h0)) err("ctrl reset");
  endtask
  task automatic t_free;
    wr(PE, 32'h100);
    wr(CT, cfg(tcpwm_pkg::mode_free, 3'h0, 2'h0, 3'h0, 1'b0));
    rd(CN);
    a = rdata;
    rd(CN);
    if (bad((rdata < a && a <= 32'h100) !== 1'b1)) err("live count");
    wait_tc();
    @(negedge pclk);
    if (bad(tc_out[0] !== 1'b0)) err("tc width");
    rd(CN);
    if (bad((rdata >= 32'hF0 && rdata <= 32'h100) !== 1'b1)) err("reload");
    wait_tc();
    wr(CT, 32'h0);
  endtask
  task automatic t_once;
    wr(PE, 32'h5);
    wr(CT, cfg(tcpwm_pkg::mode_oneshot, 3'h0, 2'h0, 3'h0, 1'b0));
    repeat (40) @(posedge pclk);
    rd(CN);
    if (bad(rdata !== 32'h0 || tc_out[0] !== 1'b0)) err("one shot");
    wr(CT, 32'h0);
  endtask
  task automatic t_en;
    wr(PE, 32'h40);
    wr(CT, cfg(tcpwm_pkg::mode_enable, 3'h0, 2'h0, 3'h0, 1'b0));
    repeat (10) @(posedge pclk);
    rd(CN);
    if (bad(rdata !== 32'h40)) err("held without enable");
    u_pins.hit(2, 1);
    rd(CP);
    if (bad(rdata !== 32'h40)) err("capture");
    for (int m = 0; m < 5; m++) begin
      for (int v = 0; v < 3; v++) begin
        wr(CM, 32'h3F + 32'(v));
        wr(CT, cfg(tcpwm_pkg::mode_enable, 3'(m), 2'h0, 3'h0, 1'b0));
        repeat (8) @(posedge pclk);
        e = m == 0 ? v > 1 : m == 1 ? v > 0 : m == 2 ? v == 1 : m == 3 ? v < 2 : v < 1;
        if (bad(cmp_out[0] !== e)) err("compare");
      end
    end
    u_pins.lvl(3, 1'b1);
    repeat (20) @(posedge pclk);
    u_pins.lvl(3, 1'b0);
    repeat (8) @(posedge pclk);
    rd(CN);
    a = rdata;
    repeat (10) @(posedge pclk);
    rd(CN);
    if (bad(rdata !== a || (a < 32'h40) !== 1'b1)) err("gated count");
    u_pins.hit(1, 1);
    rd(CN);
    if (bad(rdata !== 32'h40)) err("reset input reload");
  endtask
  task automatic t_pwm;
    wr(DB, 32'hA);
    wr(CM, 32'h50);
    wr(CT, cfg(tcpwm_pkg::mode_enable, tcpwm_pkg::cmp_less, 2'h0, 3'h0, 1'b1));
    repeat (30) @(posedge pclk);
    if (bad(cmp_out[0] !== 1'b1 || tc_out[0] !== 1'b0)) err("pwm pair");
    wr(CM, 32'h30);
    n = 0;
    ov = 1'b0;
    do begin
      @(negedge pclk);
      n++;
      ov = ov | (cmp_out[0] & tc_out[0]);
    end while (tc_out[0] !== 1'b1 && n < 60);
    if (bad(ov !== 1'b0 || n < 10 || n > 40)) err("deadband");
    u_pins.lvl(4, 1'b1);
    wr(CM, 32'h50);
    repeat (30) @(posedge pclk);
    if (bad(cmp_out[0] !== 1'b0 || tc_out[0] !== 1'b0)) err("kill");
    u_pins.lvl(4, 1'b0);
    repeat (30) @(posedge pclk);
    if (bad(cmp_out[0] !== 1'b1)) err("kill release");
    wr(CT, 32'h0);
    wr(DB, 32'h0);
  endtask
  task automatic t_irq;
    wr(ST, 32'hFFFF);
    wr(PE, 32'h10);
    wr(CT, cfg(tcpwm_pkg::mode_free, 3'h0, 2'h0, 3'h1, 1'b0));
    repeat (40) @(posedge pclk);
    rd(ST);
    if (bad(rdata[0] !== 1'b1 || irq !== 1'b0)) err("masked tc");
    wr(MK, 32'h1);
    repeat (4) @(posedge pclk);
    if (bad(irq !== 1'b1 || irq_line[0] !== 1'b1)) err("irq raise");
    wr(CT, 32'h0);
    wr(ST, 32'h1);
    repeat (4) @(posedge pclk);
    rd(ST);
    if (bad(rdata[0] !== 1'b0 || irq !== 1'b0)) err("irq clear");
    wr(CT, cfg(tcpwm_pkg::mode_enable, tcpwm_pkg::cmp_less, 2'h0, 3'h6, 1'b0));
    wr(CM, 32'h0);
    u_pins.hit(2, 1);
    wr(CM, 32'hFFFF);
    wr(MK, 32'h4);
    repeat (6) @(posedge pclk);
    rd(ST);
    if (bad(rdata[3:1] !== 3'h3 || irq !== 1'b1)) err("capture and compare events");
    wr(CT, 32'h0);
    wr(ST, 32'hFFFF);
    wr(MK, 32'h0);
  endtask
  task automatic t_clk;
    wr(PE, 32'h20);
    wr(CT, cfg(tcpwm_pkg::mode_free, 3'h0, 2'h3, 3'h0, 1'b0));
    u_pins.hit(0, 5);
    rd(CN);
    if (bad(rdata !== 32'h1B)) err("external clock");
    wr(CT, 32'h0);
    wr(PE, 32'h100);
    wr(CT, cfg(tcpwm_pkg::mode_free, 3'h0, 2'h1, 3'h0, 1'b0));
    repeat (40) @(posedge pclk);
    rd(CN);
    if (bad((rdata >= 32'hF0 && rdata <= 32'hF8) !== 1'b1)) err("prescaled clock");
    wr(12'h020 + CT, cfg(tcpwm_pkg::mode_free, 3'h0, 2'h2, 3'h0, 1'b0));
    repeat (40) @(posedge pclk);
    rd(12'h020 + CN);
    if (bad((rdata >= 32'h5 && rdata <= 32'h6) !== 1'b1)) err("second instance slow clock");
    wr(12'h020 + CT, 32'h0);
    wr(CT, 32'h0);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err("timeout");
      end_sim();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_free();
    t_once();
    t_en();
    t_pwm();
    t_irq();
    t_clk();
    end_sim();
  end
endmodule

// ### dv/tcpwm_pins.sv
// Model of the routed signals that feed the timer input pins
`timescale 1ns/1ns
module tcpwm_pins (
  input  wire logic       pclk,
  output logic      [3:0] ext_clk_in,
  output logic      [3:0] reset_in,
  output logic      [3:0] capture_in,
  output logic      [3:0] enable_in,
  output logic      [3:0] kill_in
);
  logic [4:0][3:0] g;

  initial g = '0;
  assign ext_clk_in = g[0];
  assign reset_in   = g[1];
  assign capture_in = g[2];
  assign enable_in  = g[3];
  assign kill_in    = g[4];

  // Pulses last 8 cycles each way so the input filter passes them
  task automatic hit(input int k, input int n);
    repeat (n) begin
      @(posedge pclk);
      g[k][0] <= 1'b1;
      repeat (8) @(posedge pclk);
      g[k][0] <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask

  // Level change of one routed signal
  task automatic lvl(input int k, input logic v);
    @(posedge pclk);
    g[k][0] <= v;
  endtask
endmodule

// ### dv/tcpwm_properties.sv
// Port checks of the timer block
`timescale 1ns/1ns
module tcpwm_props #(
  parameter int PRESC_A = 4,
  parameter int PRESC_B = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  kill_in,
  input wire logic [3:0]  cmp_out,
  input wire logic [3:0]  irq_line,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_kill;
    kill_in[0] [*8];
  endsequence

  property p_ready;
    pready == (psel && penable);
  endproperty
  property p_err_gate;
    pslverr |-> s_acc;
  endproperty
  property p_unaligned;
    s_acc ##0 (paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  property p_hole;
    s_acc ##0 (paddr < 12'h080 && paddr[4:3] == 2'h3) |-> pslverr;
  endproperty
  property p_err_data;
    s_acc ##0 (!pwrite && pslverr) |-> prdata == 32'h0;
  endproperty
  property p_hold;
    s_acc ##0 !pwrite ##1 !psel |-> $stable(prdata);
  endproperty
  property p_irq_or;
    irq == (|irq_line);
  endproperty
  property p_kill;
    s_kill |-> !cmp_out[0];
  endproperty

  a_ready: assert property (p_ready) else $error("pready wrong");
  a_err_gate: assert property (p_err_gate) else $error("pslverr outside access");
  a_unaligned: assert property (p_unaligned) else $error("unaligned not refused");
  a_hole: assert property (p_hole) else $error("unused offset not refused");
  a_err_data: assert property (p_err_data) else $error("refused read not zero");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_irq_or: assert property (p_irq_or) else $error("irq not or of lines");
  a_kill: assert property (p_kill) else $error("compare output not killed");
endmodule

bind tcpwm_top tcpwm_props #(.PRESC_A(PRESC_A), .PRESC_B(PRESC_B)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .kill_in, .cmp_out, .irq_line, .irq
);
